// ### ocd_defines.vh
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH
// ****************************************
// Register map of channel 0, byte addresses
// ****************************************
`define OCD_ADDR_W 16
`define OCD_CH_STRIDE 16'h000A
`define OCD_OFF_CONTROL 16'h00C8
`define OCD_OFF_DIV_LOW 16'h00C9
`define OCD_OFF_DIV_HIGH 16'h00CA
`define OCD_OFF_FINE 16'h00CB
`define OCD_OFF_COARSE 16'h00CC
`define OCD_OFF_SLIP_LOW 16'h00CD
`define OCD_OFF_SLIP_HIGH 16'h00CE
`define OCD_OFF_SOURCE 16'h00CF
// ****************************************
// Field positions and masks
// ****************************************
`define OCD_CTL_ENABLE 0
`define OCD_CTL_REPEAT 1
`define OCD_CTL_SLIP 5
`define OCD_CTL_SYNC 6
`define OCD_CTL_MASK 8'hE3
`define OCD_NIBBLE_MASK 8'h0F
`define OCD_FIVE_MASK 8'h1F
`define OCD_SOURCE_MASK 8'h03
// ****************************************
// Reset values and limits
// ****************************************
`define OCD_RST_BYTE 8'h00
`define OCD_RST_DIV_LOW 8'h02
`define OCD_FINE_MAX 5'h17
`define OCD_COARSE_MAX 5'h11
`define OCD_COARSE_STAGES 9
`define OCD_SLIP_ONE 12'h001
// ****************************************
// Output source codes
// ****************************************
`define OCD_SRC_DIVIDER 2'h0
`define OCD_SRC_DELAY 2'h1
`define OCD_SRC_PAIR 2'h2
`define OCD_SRC_INPUT 2'h3
`endif

// ### ocd_divider.v
`timescale 1ns/1ps
`include "ocd_defines.vh"
module ocd_divider (
  input wire sys_clk,
  input wire nrst,
  input wire enable,
  input wire [11:0] ratio,
  input wire syncPulse,
  input wire hold,
  output wire divOut
);
  reg [12:0] halfCount;
  reg riseLevel;
  reg fallLevel;
  reg [12:0] next_halfCount;
  wire [12:0] period;
  wire [12:0] stepped;
  assign period = {ratio, 1'b0};
  assign stepped = halfCount + 13'h0002;
  // ****************************************
  // Half-cycle phase counter
  // ****************************************
  always @* begin
    if (!enable || syncPulse) begin
      next_halfCount = 13'h0000;
    end else if (hold) begin
      next_halfCount = halfCount;
    end else if (stepped >= period) begin
      next_halfCount = stepped - period;
    end else begin
      next_halfCount = stepped;
    end
  end
  always @(posedge sys_clk) begin
    if (!nrst) begin
      halfCount <= 13'h0000;
      riseLevel <= 1'b0;
    end else begin
      halfCount <= next_halfCount;
      riseLevel <= fallLevel ^ (enable && (next_halfCount < {1'b0, ratio}));
    end
  end
  // Falling edge sets the odd half so odd ratios keep even duty
  always @(negedge sys_clk) begin
    if (!nrst) begin
      fallLevel <= 1'b0;
    end else begin
      fallLevel <= riseLevel ^ (enable && ((halfCount + 13'h0001) < {1'b0, ratio}));
    end
  end
  assign divOut = riseLevel ^ fallLevel;
endmodule

// ### ocd_coarse_delay.v
`timescale 1ns/1ps
`include "ocd_defines.vh"
module ocd_coarse_delay (
  input wire sys_clk,
  input wire nrst,
  input wire sigIn,
  input wire [4:0] code,
  output wire sigOut
);
  reg [`OCD_COARSE_STAGES-1:0] riseStage;
  reg [`OCD_COARSE_STAGES-1:0] fallStage;
  wire [3:0] pick;
  assign pick = code[4:1];
  // ****************************************
  // Full-cycle chain and half-cycle copies
  // ****************************************
  always @(posedge sys_clk) begin
    if (!nrst) begin
      riseStage <= {`OCD_COARSE_STAGES{1'b0}};
    end else begin
      riseStage <= {riseStage[`OCD_COARSE_STAGES-2:0], sigIn};
    end
  end
  always @(negedge sys_clk) begin
    if (!nrst) begin
      fallStage <= {`OCD_COARSE_STAGES{1'b0}};
    end else begin
      fallStage <= riseStage;
    end
  end
  // Odd codes add one half cycle
  assign sigOut = code[0] ? fallStage[pick] : riseStage[pick];
endmodule

// ### ocd_channel.v
`timescale 1ns/1ps
`include "ocd_defines.vh"
module ocd_channel #(
  parameter [3:0] CHANNEL = 4'h0
) (
  input wire sys_clk,
  input wire nrst,
  input wire [`OCD_ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  output reg regRdHit,
  input wire portSlipRequest,
  input wire general_input_pin,
  input wire syncEvent,
  input wire pulseRequest,
  input wire pairClock,
  output wire chOut,
  output wire divClock,
  output reg [4:0] fineDelayCode,
  output reg [4:0] coarseDelayCode,
  output wire slipBusy,
  output reg [11:0] slipRemaining
);
  // ****************************************
  // Address decode
  // ****************************************
  function hitOffset;
    input [`OCD_ADDR_W-1:0] addr;
    input [`OCD_ADDR_W-1:0] offset;
    input [3:0] chan;
    begin
      hitOffset = (addr == (offset + chan * `OCD_CH_STRIDE));
    end
  endfunction

  // ****************************************
  // Field helpers
  // ****************************************
  function [7:0] padNibble;
    input [3:0] field;
    begin
      padNibble = {4'h0, field};
    end
  endfunction

  function [7:0] padFive;
    input [4:0] field;
    begin
      padFive = {3'h0, field};
    end
  endfunction

  function codeApplies;
    input [4:0] code;
    input [4:0] limit;
    begin
      codeApplies = (code <= limit);
    end
  endfunction

  wire hitControl;
  wire hitDivLow;
  wire hitDivHigh;
  wire hitFine;
  wire hitCoarse;
  wire hitSlipLow;
  wire hitSlipHigh;
  wire hitSource;
  assign hitControl = hitOffset(regAddr, `OCD_OFF_CONTROL, CHANNEL);
  assign hitDivLow = hitOffset(regAddr, `OCD_OFF_DIV_LOW, CHANNEL);
  assign hitDivHigh = hitOffset(regAddr, `OCD_OFF_DIV_HIGH, CHANNEL);
  assign hitFine = hitOffset(regAddr, `OCD_OFF_FINE, CHANNEL);
  assign hitCoarse = hitOffset(regAddr, `OCD_OFF_COARSE, CHANNEL);
  assign hitSlipLow = hitOffset(regAddr, `OCD_OFF_SLIP_LOW, CHANNEL);
  assign hitSlipHigh = hitOffset(regAddr, `OCD_OFF_SLIP_HIGH, CHANNEL);
  assign hitSource = hitOffset(regAddr, `OCD_OFF_SOURCE, CHANNEL);

  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] control;
  reg [7:0] divLow;
  reg [3:0] divHigh;
  reg [4:0] fineField;
  reg [4:0] coarseField;
  reg [7:0] slipLow;
  reg [3:0] slipHigh;
  reg [1:0] sourceSel;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      control <= `OCD_RST_BYTE;
      divLow <= `OCD_RST_DIV_LOW;
      divHigh <= 4'h0;
      fineField <= 5'h00;
      coarseField <= 5'h00;
      slipLow <= `OCD_RST_BYTE;
      slipHigh <= 4'h0;
      sourceSel <= `OCD_SRC_DIVIDER;
    end else if (regWrEn) begin
      if (hitControl) begin
        control <= regWrData & `OCD_CTL_MASK;
      end
      if (hitDivLow) begin
        divLow <= regWrData;
      end
      if (hitDivHigh) begin
        divHigh <= regWrData[3:0];
      end
      if (hitFine) begin
        fineField <= regWrData[4:0];
      end
      if (hitCoarse) begin
        coarseField <= regWrData[4:0];
      end
      if (hitSlipLow) begin
        slipLow <= regWrData;
      end
      if (hitSlipHigh) begin
        slipHigh <= regWrData[3:0];
      end
      if (hitSource) begin
        sourceSel <= regWrData[1:0];
      end
    end
  end

  wire chanEnable;
  wire repeatEnable;
  wire slipEnable;
  wire syncEnable;
  wire [11:0] ratio;
  wire [11:0] slipAmount;
  assign chanEnable = control[`OCD_CTL_ENABLE];
  assign repeatEnable = control[`OCD_CTL_REPEAT];
  assign slipEnable = control[`OCD_CTL_SLIP];
  assign syncEnable = control[`OCD_CTL_SYNC];
  assign ratio = {divHigh, divLow};
  assign slipAmount = {slipHigh, slipLow};

  // ****************************************
  // Register read-back
  // ****************************************
  reg [7:0] next_regRdData;
  reg next_regRdHit;

  always @* begin
    next_regRdData = `OCD_RST_BYTE;
    next_regRdHit = 1'b1;
    if (hitControl) begin
      next_regRdData = control;
    end else if (hitDivLow) begin
      next_regRdData = divLow;
    end else if (hitDivHigh) begin
      next_regRdData = padNibble(divHigh);
    end else if (hitFine) begin
      next_regRdData = padFive(fineField);
    end else if (hitCoarse) begin
      next_regRdData = padFive(coarseField);
    end else if (hitSlipLow) begin
      next_regRdData = slipLow;
    end else if (hitSlipHigh) begin
      next_regRdData = padNibble(slipHigh);
    end else if (hitSource) begin
      next_regRdData = {6'h00, sourceSel};
    end else begin
      next_regRdHit = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      regRdData <= `OCD_RST_BYTE;
      regRdHit <= 1'b0;
    end else if (regRdEn) begin
      regRdData <= next_regRdData;
      regRdHit <= next_regRdHit;
    end
  end

  // ****************************************
  // Applied delay codes
  // ****************************************
  always @(posedge sys_clk) begin
    if (!nrst) begin
      fineDelayCode <= 5'h00;
      coarseDelayCode <= 5'h00;
    end else begin
      if (codeApplies(fineField, `OCD_FINE_MAX)) begin
        fineDelayCode <= fineField;
      end
      if (codeApplies(coarseField, `OCD_COARSE_MAX)) begin
        coarseDelayCode <= coarseField;
      end
    end
  end

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  reg pinMeta;
  reg pinSync;
  reg pinLast;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinLast <= 1'b0;
    end else begin
      pinMeta <= general_input_pin;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  wire pinRequest;
  assign pinRequest = pinSync && !pinLast;

  // ****************************************
  // Slip sequencer
  // ****************************************
  wire explicitSlip;
  wire groupSlip;
  wire syncPulse;
  reg [11:0] next_slipRemaining;
  assign explicitSlip = portSlipRequest || pinRequest;
  assign groupSlip = syncEvent || pulseRequest;
  assign syncPulse = chanEnable && syncEnable && syncEvent;

  always @* begin
    next_slipRemaining = slipRemaining;
    if (!chanEnable || !slipEnable) begin
      next_slipRemaining = 12'h000;
    end else if (repeatEnable && (explicitSlip || groupSlip)) begin
      next_slipRemaining = slipAmount;
    end else if (!repeatEnable && explicitSlip) begin
      next_slipRemaining = `OCD_SLIP_ONE;
    end else if (slipRemaining != 12'h000) begin
      next_slipRemaining = slipRemaining - `OCD_SLIP_ONE;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      slipRemaining <= 12'h000;
    end else begin
      slipRemaining <= next_slipRemaining;
    end
  end

  assign slipBusy = (slipRemaining != 12'h000);

  // ****************************************
  // Divider and coarse delay
  // ****************************************
  ocd_divider divider (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(chanEnable),
    .ratio(ratio),
    .syncPulse(syncPulse),
    .hold(slipBusy),
    .divOut(divClock)
  );

  wire delayedClock;

  ocd_coarse_delay coarse (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sigIn(divClock),
    .code(coarseDelayCode),
    .sigOut(delayedClock)
  );

  // ****************************************
  // Undivided input clock regeneration
  // ****************************************
  reg fundRise;
  reg fundFall;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      fundRise <= 1'b0;
    end else begin
      fundRise <= fundFall ^ chanEnable;
    end
  end

  always @(negedge sys_clk) begin
    if (!nrst) begin
      fundFall <= 1'b0;
    end else begin
      fundFall <= fundRise;
    end
  end

  wire fundClock;
  assign fundClock = fundRise ^ fundFall;

  // ****************************************
  // Output source selection
  // ****************************************
  reg selected;

  always @* begin
    case (sourceSel)
      `OCD_SRC_DIVIDER: begin
        selected = divClock;
      end
      `OCD_SRC_DELAY: begin
        selected = delayedClock;
      end
      `OCD_SRC_PAIR: begin
        selected = pairClock;
      end
      `OCD_SRC_INPUT: begin
        selected = fundClock;
      end
      default: begin
        selected = 1'b0;
      end
    endcase
  end

  assign chOut = chanEnable && selected;
endmodule

// ### ocd_monitor.sv
`timescale 1ns/1ps
`include "ocd_defines.vh"
// ****************************************
// Channel checker
// ****************************************
module ocd_monitor #(
  parameter [3:0] CHANNEL = 4'h0
) (
  input logic sys_clk,
  input logic nrst,
  input logic [15:0] regAddr,
  input logic [7:0] regWrData,
  input logic regWrEn,
  input logic regRdEn,
  input logic [7:0] regRdData,
  input logic regRdHit,
  input logic portSlipRequest,
  input logic general_input_pin,
  input logic syncEvent,
  input logic pulseRequest,
  input logic chOut,
  input logic [4:0] fineDelayCode,
  input logic [4:0] coarseDelayCode,
  input logic slipBusy,
  input logic [11:0] slipRemaining
);
  localparam [15:0] BASE = `OCD_OFF_CONTROL + `OCD_CH_STRIDE * CHANNEL;
  logic [7:0] ctl;
  logic [11:0] amt;
  logic [3:0] pinHist;
  logic quiet;
  logic anyReq;
  assign quiet = !general_input_pin && pinHist == 4'h0;
  assign anyReq = portSlipRequest || syncEvent || pulseRequest || !quiet;
  // Shadow of control byte and repeat amount
  always @(posedge sys_clk) begin
    pinHist <= {pinHist[2:0], general_input_pin};
    if (!nrst) begin
      ctl <= 8'h00;
      amt <= 12'h000;
    end else if (regWrEn) begin
      if (regAddr == BASE) ctl <= regWrData;
      if (regAddr == BASE + 16'h0005) amt[7:0] <= regWrData;
      if (regAddr == BASE + 16'h0006) amt[11:8] <= regWrData[3:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_disabled_low: assert property (!ctl[0] |-> !chOut)
    else $error("output active while disabled");
  chk_fine_limit: assert property (fineDelayCode <= `OCD_FINE_MAX)
    else $error("fine code out of range");
  chk_coarse_limit: assert property (coarseDelayCode <= `OCD_COARSE_MAX)
    else $error("coarse code out of range");
  chk_read_hit: assert property (regRdEn && regAddr >= BASE && regAddr <= BASE + 16'h0007
    |=> regRdHit) else $error("mapped read missed");
  chk_read_miss: assert property (regRdEn && (regAddr < BASE || regAddr > BASE + 16'h0007)
    |=> !regRdHit && regRdData == 8'h00) else $error("unmapped read answered");
  chk_single_slip: assert property (ctl[0] && ctl[5] && !ctl[1] && portSlipRequest
    |=> slipRemaining == `OCD_SLIP_ONE) else $error("single slip not loaded");
  chk_repeat_load: assert property (ctl[0] && ctl[5] && ctl[1]
    && (portSlipRequest || syncEvent || pulseRequest) |=> slipRemaining == amt)
    else $error("repeat amount not loaded");
  chk_no_auto: assert property (!ctl[1] && !slipBusy && !portSlipRequest && quiet
    && (syncEvent || pulseRequest) |=> !slipBusy) else $error("automatic slip started");
  chk_count_down: assert property (slipBusy && !anyReq && !regWrEn
    |=> slipRemaining == $past(slipRemaining) - 12'h001) else $error("slip count wrong");
endmodule

bind ocd_channel ocd_monitor #(.CHANNEL(CHANNEL)) u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdHit(regRdHit),
  .portSlipRequest(portSlipRequest), .general_input_pin(general_input_pin),
  .syncEvent(syncEvent), .pulseRequest(pulseRequest), .chOut(chOut),
  .fineDelayCode(fineDelayCode), .coarseDelayCode(coarseDelayCode),
  .slipBusy(slipBusy), .slipRemaining(slipRemaining)
);

// ### output_channel_divider_delay_slip_tb.sv
`timescale 1ns/1ps
`include "ocd_defines.vh"
// ****************************************
// Channel testbench
// ****************************************
module output_channel_divider_delay_slip_tb;
  localparam logic [63:0] MSK = 64'h030FFF1F1F0FFFE3;
  logic sys_clk, nrst, regWrEn, regRdEn, portSlipRequest, general_input_pin;
  logic syncEvent, pulseRequest, pairClock, regRdHit, chOut, divClock, slipBusy;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [4:0] fineDelayCode, coarseDelayCode;
  logic [11:0] slipRemaining;
  logic [79:0] capDiv, capOut, prevOut;
  int num_errors, num_checks, i, d0;
  int cycles = 0;
  int rl[6] = '{1, 2, 3, 5, 6, 4094};
  int cl[4] = '{0, 1, 17, 20};
  ocd_channel dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdHit(regRdHit),
    .portSlipRequest(portSlipRequest), .general_input_pin(general_input_pin),
    .syncEvent(syncEvent), .pulseRequest(pulseRequest), .pairClock(pairClock),
    .chOut(chOut), .divClock(divClock), .fineDelayCode(fineDelayCode),
    .coarseDelayCode(coarseDelayCode), .slipBusy(slipBusy), .slipRemaining(slipRemaining));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done;
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] d, input logic h);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    @(negedge sys_clk);
    chk({3'h0, regRdHit, regRdData}, {3'h0, h, d});
  endtask
  task ratio(input logic [11:0] n);
    wr(`OCD_OFF_DIV_LOW, n[7:0]);
    wr(`OCD_OFF_DIV_HIGH, {4'h0, n[11:8]});
    @(negedge sys_clk);
    syncEvent = 1'b1;
    @(negedge sys_clk);
    syncEvent = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task cap;
    for (int k = 0; k < 80; k++) begin
      @(sys_clk);
      #1;
      capDiv[k] = divClock;
      capOut[k] = chOut;
      if (k == 1) syncEvent = 1'b0;
    end
  endtask
  function int offs(input logic [79:0] r, input logic [79:0] s);
    bit ok;
    for (int d = 0; d < 40; d++) begin
      ok = 1;
      for (int k = d; k < 80; k++) if (s[k] !== r[k - d]) ok = 0;
      if (ok) return d;
    end
    return 99;
  endfunction
  task duty(input int n);
    int h, t;
    logic p;
    h = 0;
    t = 0;
    @(posedge sys_clk);
    #1 p = chOut;
    for (int k = 0; k < 2 * n; k++) begin
      @(sys_clk);
      #1;
      h += (chOut === 1'b1);
      t += (chOut !== p);
      p = chOut;
    end
    chk(12'(h), 12'(n));
    chk(12'(t), 12'h002);
  endtask
  task req(input logic [3:0] k, input logic [11:0] exp);
    logic [11:0] v;
    bit got;
    v = 12'h000;
    got = 0;
    @(negedge sys_clk);
    {general_input_pin, pulseRequest, syncEvent, portSlipRequest} = k;
    repeat (10) begin
      @(negedge sys_clk);
      {general_input_pin, pulseRequest, syncEvent, portSlipRequest} = 4'h0;
      if (slipBusy === 1'b1 && !got) begin
        v = slipRemaining;
        got = 1;
      end
    end
    chk(v, exp);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, regWrEn, regRdEn, portSlipRequest, general_input_pin} = 5'h00;
    {syncEvent, pulseRequest, pairClock} = 3'h0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    for (i = 0; i < 8; i++) rd(16'(16'h00C8 + i), i == 1 ? 8'h02 : 8'h00, 1'b1);
    for (i = 0; i < 8; i++) begin
      wr(16'(16'h00C8 + i), 8'hFF);
      rd(16'(16'h00C8 + i), MSK[8 * i +: 8], 1'b1);
    end
    rd(16'h00C7, 8'h00, 1'b0);
    rd(16'h00D0, 8'h00, 1'b0);
    wr(`OCD_OFF_FINE, 8'h17);
    wr(`OCD_OFF_COARSE, 8'h11);
    @(negedge sys_clk);
    chk({2'h0, fineDelayCode, coarseDelayCode}, {2'h0, 5'h17, 5'h11});
    wr(`OCD_OFF_FINE, 8'h18);
    wr(`OCD_OFF_COARSE, 8'h12);
    @(negedge sys_clk);
    chk({2'h0, fineDelayCode, coarseDelayCode}, {2'h0, 5'h17, 5'h11});
    wr(`OCD_OFF_COARSE, 8'h00);
    wr(`OCD_OFF_SOURCE, 8'h03);
    wr(`OCD_OFF_CONTROL, 8'h00);
    repeat (4) @(negedge sys_clk);
    wr(`OCD_OFF_CONTROL, 8'h41);
    duty(1);
    wr(`OCD_OFF_SOURCE, 8'h02);
    pairClock = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({11'h0, chOut}, 12'h001);
    pairClock = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({11'h0, chOut}, 12'h000);
    wr(`OCD_OFF_SOURCE, 8'h00);
    for (i = 0; i < 6; i++) begin
      ratio(12'(rl[i]));
      duty(rl[i]);
    end
    ratio(12'h004);
    @(negedge sys_clk);
    syncEvent = 1'b1;
    cap;
    chk({7'h0, capOut[4:0]}, 12'h00F);
    wr(`OCD_OFF_CONTROL, 8'h61);
    cap;
    prevOut = capOut;
    req(4'h1, 12'h001);
    @(negedge sys_clk);
    cap;
    chk(12'(offs(prevOut, capOut)), 12'h002);
    wr(`OCD_OFF_SLIP_LOW, 8'h03);
    wr(`OCD_OFF_SLIP_HIGH, 8'h00);
    wr(`OCD_OFF_CONTROL, 8'h63);
    cap;
    prevOut = capOut;
    req(4'h4, 12'h003);
    @(negedge sys_clk);
    cap;
    chk(12'(offs(prevOut, capOut)), 12'h006);
    req(4'h2, 12'h003);
    req(4'h8, 12'h003);
    req(4'h1, 12'h003);
    wr(`OCD_OFF_CONTROL, 8'h61);
    req(4'h8, 12'h001);
    req(4'h2, 12'h000);
    req(4'h4, 12'h000);
    wr(`OCD_OFF_CONTROL, 8'h43);
    req(4'h1, 12'h000);
    wr(`OCD_OFF_CONTROL, 8'h41);
    ratio(12'h014);
    wr(`OCD_OFF_SOURCE, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(`OCD_OFF_COARSE, 8'(cl[i]));
      repeat (30) @(negedge sys_clk);
      cap;
      if (i == 0) d0 = offs(capDiv, capOut);
      chk(12'(offs(capDiv, capOut) - d0), cl[i] > 17 ? 12'h011 : 12'(cl[i]));
    end
    test_done;
  end
endmodule
